// ### core/arp_params.svh
// constants for the master port read-address block
`ifndef ARP_PARAMS_SVH
`define ARP_PARAMS_SVH

// ************************************************************
// port structure
// ************************************************************
`define ARP_NUM_PORTS 2
`define ARP_PORT1_PRESENT 1'b1
`define ARP_ADDR_W 32
`define ARP_ID_W 4
`define ARP_CACHE_W 4
`define ARP_LEN_W 4
`define ARP_BURST_W 2

// ************************************************************
// encodings
// ************************************************************
`define ARP_BURST_INCR 2'h1
`define ARP_BURST_WRAP 2'h2
`define ARP_LEN_CACHEABLE 4'h3
`define ARP_CACHEABLE_BIT 1
`define ARP_RESET_STATE '0

`endif

// ### core/arp_pkg.sv
// types shared by the master port read-address block
`include "arp_params.svh"

package arp_pkg;

    // request from the cluster side
    typedef struct packed {
        logic [`ARP_ADDR_W-1:0] addr;
        logic [`ARP_CACHE_W-1:0] cache;
        logic [`ARP_ID_W-1:0] id;
        logic [`ARP_LEN_W-1:0] len;
        logic wrap;
    } arp_req_s;

    // read-address channel fields as driven on the bus
    typedef struct packed {
        logic [`ARP_ADDR_W-1:0] addr;
        logic [`ARP_BURST_W-1:0] burst;
        logic [`ARP_CACHE_W-1:0] cache;
        logic [`ARP_ID_W-1:0] id;
        logic [`ARP_LEN_W-1:0] len;
    } arp_ar_s;

    // per-port state
    typedef struct packed {
        arp_ar_s ar;
        logic valid;
        logic ack;
        logic pend_valid;
        arp_req_s pend;
        logic req_ready;
    } arp_port_s;

    // whole state of the block
    typedef struct packed {
        arp_port_s [`ARP_NUM_PORTS-1:0] port;
    } arp_state_s;

endpackage

// ### core/arp_read_port.sv
// read-address channels of the primary and secondary master ports
`timescale 1ns/1ps
`include "arp_params.svh"

module arp_read_port (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // bus pacing enables, one per port
    input wire logic [`ARP_NUM_PORTS-1:0] port_input_sample_enable,
    input wire logic [`ARP_NUM_PORTS-1:0] port_output_update_enable,
    // cluster side request, one per port
    input wire logic [`ARP_NUM_PORTS-1:0] req_valid,
    input wire arp_pkg::arp_req_s [`ARP_NUM_PORTS-1:0] req,
    output logic [`ARP_NUM_PORTS-1:0] req_ready,
    // read-address channel, one per port
    output logic [`ARP_NUM_PORTS-1:0] port_read_valid,
    input wire logic [`ARP_NUM_PORTS-1:0] port_read_ready,
    output logic [`ARP_NUM_PORTS-1:0][`ARP_ADDR_W-1:0] port_read_address,
    output logic [`ARP_NUM_PORTS-1:0][`ARP_BURST_W-1:0] port_read_burst_type,
    output logic [`ARP_NUM_PORTS-1:0][`ARP_CACHE_W-1:0] port_read_cache_type,
    output logic [`ARP_NUM_PORTS-1:0][`ARP_ID_W-1:0] port_read_request_id,
    output logic [`ARP_NUM_PORTS-1:0][`ARP_LEN_W-1:0] port_read_burst_length
);
    import arp_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************

    // burst length: cacheable traffic is forced to four transfers
    function automatic logic [`ARP_LEN_W-1:0] arp_burst_len(
        input arp_req_s r
    );
        if (r.cache[`ARP_CACHEABLE_BIT]) begin
            arp_burst_len = `ARP_LEN_CACHEABLE;
        end else begin
            arp_burst_len = r.len;
        end
    endfunction

    // build the bus beat from a queued request
    function automatic arp_ar_s arp_to_ar(input arp_req_s r);
        arp_to_ar.addr = r.addr;
        arp_to_ar.cache = r.cache;
        arp_to_ar.id = r.id;
        arp_to_ar.len = arp_burst_len(r);
        // only the two legal encodings can ever be produced
        arp_to_ar.burst = r.wrap ? `ARP_BURST_WRAP : `ARP_BURST_INCR;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    arp_state_s state_reg;
    arp_state_s state_next;
    logic [`ARP_NUM_PORTS-1:0] present;
    logic [`ARP_NUM_PORTS-1:0] hs_now;
    logic [`ARP_NUM_PORTS-1:0] load_now;

    // per-port handshake and load decisions
    genvar gp;
    generate
        for (gp = 0; gp < `ARP_NUM_PORTS; gp++) begin : g_dec
            // port 1 may be configured out; port 0 always exists
            assign present[gp] = (gp == 0) || `ARP_PORT1_PRESENT;
            // ready only counts on an input-enabled edge
            assign hs_now[gp] = state_reg.port[gp].valid &
                port_input_sample_enable[gp] & port_read_ready[gp];
            // the beat may only move on an output-enabled edge
            assign load_now[gp] = present[gp] &
                port_output_update_enable[gp] &
                (~state_reg.port[gp].valid | state_reg.port[gp].ack |
                 hs_now[gp]);
        end
    endgenerate

    // next state: one holding slot per port feeds the bus register
    always_comb begin
        state_next = state_reg;
        for (int p = 0; p < `ARP_NUM_PORTS; p++) begin
            // remember an accepted beat until the next output edge
            if (hs_now[p]) begin
                state_next.port[p].ack = 1'b1;
            end
            // ready is registered, so take a request only into an empty slot
            if (present[p] & req_valid[p] & state_reg.port[p].req_ready) begin
                state_next.port[p].pend = req[p];
                state_next.port[p].pend_valid = 1'b1;
            end
            // outputs hold between enables; the slave's pacing keeps the
            // valid from being seen twice across one handshake
            if (load_now[p]) begin
                state_next.port[p].valid = state_reg.port[p].pend_valid;
                state_next.port[p].ack = 1'b0;
                if (state_reg.port[p].pend_valid) begin
                    state_next.port[p].ar = arp_to_ar(state_reg.port[p].pend);
                    state_next.port[p].pend_valid = 1'b0;
                end
            end
            state_next.port[p].req_ready = present[p] &
                ~state_next.port[p].pend_valid;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= `ARP_RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // outputs, straight from the state register
    // ************************************************************
    generate
        for (gp = 0; gp < `ARP_NUM_PORTS; gp++) begin : g_out
            assign req_ready[gp] = state_reg.port[gp].req_ready;
            assign port_read_valid[gp] = state_reg.port[gp].valid;
            assign port_read_address[gp] = state_reg.port[gp].ar.addr;
            assign port_read_burst_type[gp] = state_reg.port[gp].ar.burst;
            assign port_read_cache_type[gp] = state_reg.port[gp].ar.cache;
            assign port_read_request_id[gp] = state_reg.port[gp].ar.id;
            assign port_read_burst_length[gp] = state_reg.port[gp].ar.len;

            // ********************************************************
            // checks
            // ********************************************************
            hold_when_gated_a: assert property (
                @(posedge sys_clk) disable iff (srst)
                !port_output_update_enable[gp] |=>
                    $stable(state_reg.port[gp].ar) &&
                    $stable(state_reg.port[gp].valid))
                else $error("read address changed without output enable");

            sample_gated_a: assert property (
                @(posedge sys_clk) disable iff (srst)
                state_reg.port[gp].valid && !state_reg.port[gp].ack &&
                !port_input_sample_enable[gp] &&
                !port_output_update_enable[gp] |=>
                    !state_reg.port[gp].ack)
                else $error("ready taken without input enable");

            cache_passed_a: assert property (
                @(posedge sys_clk) disable iff (srst)
                load_now[gp] && state_reg.port[gp].pend_valid |=>
                    port_read_cache_type[gp] ==
                    $past(state_reg.port[gp].pend.cache))
                else $error("cache type not carried to the bus");

            cache_len_a: assert property (
                @(posedge sys_clk) disable iff (srst)
                port_read_valid[gp] &&
                port_read_cache_type[gp][`ARP_CACHEABLE_BIT] |->
                    port_read_burst_length[gp] == `ARP_LEN_CACHEABLE)
                else $error("cacheable read not four transfers");

            burst_legal_a: assert property (
                @(posedge sys_clk) disable iff (srst)
                port_read_valid[gp] |->
                    port_read_burst_type[gp] == `ARP_BURST_INCR ||
                    port_read_burst_type[gp] == `ARP_BURST_WRAP)
                else $error("reserved burst type driven");

            valid_paced_a: assert property (
                @(posedge sys_clk) disable iff (srst)
                $rose(port_read_valid[gp]) |->
                    $past(port_output_update_enable[gp]))
                else $error("valid rose off the output pace");

            absent_idle_a: assert property (
                @(posedge sys_clk) disable iff (srst)
                !present[gp] |-> !port_read_valid[gp] && !req_ready[gp])
                else $error("absent port is active");
        end
    endgenerate

endmodule // arp_read_port

// ### bench/arp_slave_model.sv
// far-side read-address slave model, one instance serving every master port
`timescale 1ns/1ps
`include "arp_params.svh"

module arp_slave_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // pacing enables, the same ones the device sees
    input wire logic [`ARP_NUM_PORTS-1:0] in_en,
    input wire logic [`ARP_NUM_PORTS-1:0] out_en,
    // read-address channel
    input wire logic [`ARP_NUM_PORTS-1:0] valid,
    input wire arp_pkg::arp_ar_s [`ARP_NUM_PORTS-1:0] bus,
    output logic [`ARP_NUM_PORTS-1:0] ready,
    // bench control and captured beats
    input wire logic [`ARP_NUM_PORTS-1:0] stall,
    output arp_pkg::arp_ar_s [`ARP_NUM_PORTS-1:0] beat,
    output logic [`ARP_NUM_PORTS-1:0] stb
);
    import arp_pkg::*;
    logic [`ARP_NUM_PORTS-1:0] taken_reg;
    logic [`ARP_NUM_PORTS-1:0] take;

    // ready may drop at any time, the slave is not obliged to hold it
    assign ready = ~stall;
    // a handshake not yet counted for the beat now on the bus
    assign take = valid & ready & in_en & ~taken_reg;

    // a beat counts once; it may linger until the next output enable
    always_ff @(posedge sys_clk) begin
        for (int p = 0; p < `ARP_NUM_PORTS; p++) begin
            if (srst) begin
                taken_reg[p] <= 1'b0;
                stb[p] <= 1'b0;
            end else begin
                stb[p] <= take[p];
                if (take[p]) begin
                    beat[p] <= bus[p];
                    taken_reg[p] <= ~out_en[p];
                end else if (out_en[p]) begin
                    taken_reg[p] <= 1'b0;
                end
            end
        end
    end
endmodule // arp_slave_model

// ### bench/tb_top.sv
// self-checking bench for the master port read-address block
`timescale 1ns/1ps
`include "arp_params.svh"

module tb_top;
    import arp_pkg::*;
    localparam int NP = `ARP_NUM_PORTS;
    localparam int RW = $bits(arp_req_s);
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [NP-1:0] in_en = '1, out_en = '1, stall = '0, req_valid = '0;
    logic [NP-1:0] req_ready, rd_valid, rd_ready, stb, snap_v, snap_oe;
    arp_req_s [NP-1:0] req = '0;
    arp_ar_s [NP-1:0] cur, beat, snap;
    logic [NP-1:0][`ARP_ADDR_W-1:0] addr;
    logic [NP-1:0][`ARP_BURST_W-1:0] burst;
    logic [NP-1:0][`ARP_CACHE_W-1:0] cache;
    logic [NP-1:0][`ARP_ID_W-1:0] id;
    logic [NP-1:0][`ARP_LEN_W-1:0] len;
    arp_ar_s exp_q[NP][$];
    int num_errors = 0, cmp_count = 0, cycles = 0, mode = 0;
    integer seed = 32'hdc37f391;
    logic snap_rst = 1'b1;

    arp_read_port arp_read_port_inst (.sys_clk(sys_clk), .srst(srst),
        .port_input_sample_enable(in_en), .port_output_update_enable(out_en),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .port_read_valid(rd_valid), .port_read_ready(rd_ready),
        .port_read_address(addr), .port_read_burst_type(burst),
        .port_read_cache_type(cache), .port_read_request_id(id),
        .port_read_burst_length(len));
    arp_slave_model arp_slave_model_inst (.sys_clk(sys_clk), .srst(srst),
        .in_en(in_en), .out_en(out_en), .valid(rd_valid), .bus(cur),
        .ready(rd_ready), .stall(stall), .beat(beat), .stb(stb));

    // gather each port's fields into one beat
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            cur[p] = '{addr[p], burst[p], cache[p], id[p], len[p]};
        end
    end

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // cacheable reads become four beats; wrap picks the wrapping type
    function automatic arp_ar_s expect_beat(input arp_req_s r);
        logic [`ARP_LEN_W-1:0] l;
        l = r.cache[`ARP_CACHEABLE_BIT] ? `ARP_LEN_CACHEABLE : r.len;
        return '{r.addr, r.wrap ? `ARP_BURST_WRAP : `ARP_BURST_INCR,
                 r.cache, r.id, l};
    endfunction

    // pacing: 0 full rate, 1 random enables and stalls, 2 fixed ratios
    always @(posedge sys_clk) begin
        cycles++;
        #1;
        if (mode == 1) begin
            in_en = NP'($random(seed));
            out_en = NP'($random(seed));
            stall = NP'($random(seed));
        end else if (mode == 2) begin
            out_en = {cycles % 3 != 0, cycles[0]};
            in_en = {cycles % 3 != 1, ~cycles[0]};
            // a stall left over from the random mode would starve a port
            stall = '0;
        end else begin
            in_en = '1;
            out_en = '1;
            stall = '0;
        end
    end

    // hang guard, generous against some three hundred busy cycles
    always @(posedge sys_clk) begin
        if (cycles > 30000) begin
            num_errors++;
            conclude();
        end
    end

    // outputs frozen without output enable; beats match in order
    always @(negedge sys_clk) begin
        for (int p = 0; p < NP; p++) begin
            if (!snap_oe[p] && !snap_rst) begin
                check({snap_v[p], snap[p]}, {rd_valid[p], cur[p]});
            end
            if (stb[p] === 1'b1 && exp_q[p].size() == 0) begin
                check(1, 0);
            end else if (stb[p] === 1'b1) begin
                check(beat[p], exp_q[p].pop_front());
            end
        end
        snap = cur;
        snap_v = rd_valid;
        snap_oe = out_en;
        snap_rst = srst;
    end

    task automatic send(input int p, input arp_req_s r);
        int n;
        n = 0;
        @(posedge sys_clk);
        #1;
        req[p] = r;
        req_valid[p] = 1'b1;
        @(negedge sys_clk);
        while (req_ready[p] !== 1'b1 && n < 300) begin
            n++;
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        #1;
        req_valid[p] = 1'b0;
        exp_q[p].push_back(expect_beat(r));
    endtask

    // corner requests first, then random ones; each port on its own
    task automatic run_port(input int p);
        arp_req_s r;
        for (int k = 0; k < 16; k++) begin
            r = RW'({$random(seed), $random(seed)});
            if (k < 4) begin
                r = '{32'hFFFF_FFF0 | k, 4'(k * 5), 4'(p * 8 + k),
                      4'hF - 4'(k), k[0]};
            end
            send(p, r);
        end
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check({req_ready, rd_valid}, '0);
        @(posedge sys_clk);
        #1;
        srst = 1'b0;
        for (int m = 0; m < 3; m++) begin
            mode = m;
            fork
                run_port(0);
                run_port(1);
            join
        end
        mode = 0;
        repeat (40) @(posedge sys_clk);
        check(exp_q[0].size(), 0);
        check(exp_q[1].size(), 0);
        conclude();
    end
endmodule // tb_top
